// ### hw/tcc_pkg.sv
// Behaviour
// R1 - One config word per thermocouple channel
// R2 - Type taken from word bits 31..27
// R3 - Codes 1..9: eight ROM curves, custom
// R4 - Custom type fetches coefficients from RAM
// R5 - Cold junction pointer names channel 1..20
// R6 - Cold junction measured with every conversion
// R7 - Result compensated for cold junction temperature
// R8 - Bit 21: one single-ended, zero differential
// R9 - Single-ended to common, differential to lower
// R10 - Bit 20 enables open circuit; 19..18 current
// R11 - 8 ms burst, 50 ms before conversion
// R12 - Custom address bits 11..6, length 5..0
// R13 - Host writes zero to bits 17..12
package tcc_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int OC_BURST_MS = 8;
    localparam int OC_LEAD_MS = 50;
    localparam int OC_BURST_CYC = OC_BURST_MS * (CLK_HZ / 1000);
    localparam int OC_LEAD_CYC = OC_LEAD_MS * (CLK_HZ / 1000);
    localparam int NUM_CH = 20;

    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] RESULT_OFF = 12'h008;
    localparam logic [11:0] CFG_BASE = 12'h080;
    localparam logic [11:0] CFG_LAST = CFG_BASE + 12'((NUM_CH - 1) * 4);

    localparam int TYPE_LSB = 27;
    localparam int CJ_LSB = 22;
    localparam int SGL_BIT = 21;
    localparam int OCEN_BIT = 20;
    localparam int OCCUR_LSB = 18;
    localparam int CADDR_LSB = 6;
    localparam int CLEN_LSB = 0;
    localparam int CTRL_START_BIT = 7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_FAULT_BIT = 3;

    localparam logic [4:0] TC_TYPE_FIRST = 5'h01;
    localparam logic [4:0] TC_TYPE_CUSTOM = 5'h09;
    localparam logic [4:0] CH_FIRST = 5'h01;
    localparam logic [4:0] CH_LAST = 5'h14;

    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] tc_chan;
        logic [4:0] tc_type;
        logic [4:0] cj_chan;
        logic differential_select;
        logic [4:0] neg_chan;
        logic open_circuit_detect_enable;
        logic [1:0] open_circuit_current_select;
    } tcc_meas_s;

    typedef struct packed {
        logic [5:0] addr;
        logic [5:0] len_m1;
    } tcc_fetch_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OC_BURST,
        ST_OC_WAIT,
        ST_CONV,
        ST_FETCH,
        ST_COMP
    } tcc_state_e;

endpackage

// ### hw/tcc_channel_cfg.sv
module tcc_channel_cfg
    import tcc_pkg::*;
#(
    parameter int unsigned BURST_CYC = OC_BURST_CYC,
    parameter int unsigned LEAD_CYC = OC_LEAD_CYC,
    parameter int TMR_W = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic oc_burst,
    output logic adc_req,
    output logic cj_req,
    output tcc_meas_s meas,
    input wire logic adc_done,
    input wire logic adc_fault,
    output logic fetch_req,
    output tcc_fetch_s fetch,
    input wire logic fetch_ack,
    output logic comp_req,
    input wire logic comp_done,
    input wire logic [31:0] comp_result
);

    localparam logic [TMR_W-1:0] BURST_END = TMR_W'(BURST_CYC - 1);
    localparam logic [TMR_W-1:0] LEAD_END = TMR_W'(LEAD_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic in_cfg(input logic [11:0] a);
        return (a >= CFG_BASE) && (a <= CFG_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [4:0] cfg_index(input logic [11:0] a);
        logic [11:0] off;
        off = a - CFG_BASE;
        return off[6:2];
    endfunction

    // Bus slave state
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [11:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire, wr_ctrl, wr_stat, wr_cfg, wr_hit;
    logic [4:0] wr_idx;
    logic [31:0] rd_val;
    logic rd_hit;

    // Channel configuration memory
    logic [31:0] cfg_q [NUM_CH];
    logic [31:0] cfg_d [NUM_CH];

    // Sequencer state
    tcc_state_e state_q, state_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    tcc_meas_s meas_q, meas_d;
    tcc_fetch_s fetch_q, fetch_d;
    logic custom_q, custom_d;
    logic done_q, done_d, err_q, err_d, fault_q, fault_d;
    logic [31:0] result_q, result_d;
    logic [4:0] chan_q, chan_d;

    // Selected channel decode
    logic start_cmd, new_ok;
    logic [4:0] new_ch, new_idx, n_type, n_cj;
    logic [31:0] new_word;
    logic n_sgl;

    assign awready = ce && !aw_got_q && !bvalid_q;
    assign wready = ce && !w_got_q && !bvalid_q;
    assign arready = ce && !rvalid_q;
    assign bvalid = ce && bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = ce && rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_cfg = 1'b0;
        if (waddr_q == CTRL_OFF) begin
            wr_ctrl = 1'b1;
        end else if (waddr_q == STAT_OFF) begin
            wr_stat = 1'b1;
        end else if (in_cfg(waddr_q)) begin
            wr_cfg = 1'b1;
        end
        wr_hit = wr_ctrl || wr_stat || wr_cfg || (waddr_q == RESULT_OFF);
        wr_idx = cfg_index(waddr_q);
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (araddr == CTRL_OFF) begin
            rd_val[4:0] = chan_q;
        end else if (araddr == STAT_OFF) begin
            rd_val[STAT_BUSY_BIT] = (state_q != ST_IDLE);
            rd_val[STAT_DONE_BIT] = done_q;
            rd_val[STAT_ERR_BIT] = err_q;
            rd_val[STAT_FAULT_BIT] = fault_q;
        end else if (araddr == RESULT_OFF) begin
            rd_val = result_q;
        end else if (in_cfg(araddr)) begin
            rd_val = cfg_q[cfg_index(araddr)];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (awvalid && awready) begin
            aw_got_d = 1'b1;
            waddr_d = awaddr;
        end
        if (wvalid && wready) begin
            w_got_d = 1'b1;
            wdata_d = wdata;
            wstrb_d = wstrb;
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rdata_d = rd_val;
            rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // One word per channel, stored as written
    for (genvar g = 0; g < NUM_CH; g++) begin : g_cfg
        always_comb begin
            cfg_d[g] = cfg_q[g];
            if (wr_fire && wr_cfg && (wr_idx == 5'(g))) begin
                cfg_d[g] = merge_bytes(cfg_q[g], wdata_q, wstrb_q); // [R1]
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg_q[g] <= CFG_RST;
            end else if (ce) begin
                cfg_q[g] <= cfg_d[g];
            end
        end
    end

    // Bits 17..12 are never looked at
    always_comb begin
        new_ch = wdata_q[4:0];
        new_idx = new_ch - CH_FIRST;
        new_word = CFG_RST;
        if (new_ch >= CH_FIRST && new_ch <= CH_LAST) begin
            new_word = cfg_q[new_idx]; // [R1] [R13]
        end
        n_type = new_word[TYPE_LSB +: 5]; // [R2]
        n_cj = new_word[CJ_LSB +: 5]; // [R5]
        n_sgl = new_word[SGL_BIT]; // [R8]
        new_ok = (new_ch >= CH_FIRST) && (new_ch <= CH_LAST)
            && (n_type >= TC_TYPE_FIRST) && (n_type <= TC_TYPE_CUSTOM) // [R3]
            && (n_cj >= CH_FIRST) && (n_cj <= CH_LAST) // [R5]
            && (n_sgl || new_ch != CH_FIRST); // [R9]
        start_cmd = wr_fire && wr_ctrl && wstrb_q[0]
            && wdata_q[CTRL_START_BIT] && (state_q == ST_IDLE);
    end

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        meas_d = meas_q;
        fetch_d = fetch_q;
        custom_d = custom_q;
        done_d = done_q;
        err_d = err_q;
        fault_d = fault_q;
        result_d = result_q;
        chan_d = chan_q;
        if (wr_fire && wr_stat && wstrb_q[0]) begin
            done_d = done_q && !wdata_q[STAT_DONE_BIT];
            err_d = err_q && !wdata_q[STAT_ERR_BIT];
            fault_d = fault_q && !wdata_q[STAT_FAULT_BIT];
        end
        case (state_q)
            ST_IDLE: begin
                if (start_cmd) begin
                    chan_d = new_ch;
                    tmr_d = '0;
                    if (new_ok) begin
                        meas_d.tc_chan = new_ch;
                        meas_d.tc_type = n_type; // [R2] [R3]
                        meas_d.cj_chan = n_cj; // [R5]
                        meas_d.differential_select = !n_sgl; // [R8]
                        meas_d.neg_chan = n_sgl ? 5'h00 : new_ch - CH_FIRST; // [R9]
                        meas_d.open_circuit_detect_enable =
                            new_word[OCEN_BIT]; // [R10]
                        meas_d.open_circuit_current_select =
                            new_word[OCCUR_LSB +: 2]; // [R10]
                        fetch_d.addr = new_word[CADDR_LSB +: 6]; // [R12]
                        fetch_d.len_m1 = new_word[CLEN_LSB +: 6]; // [R12]
                        custom_d = (n_type == TC_TYPE_CUSTOM); // [R4]
                        state_d = new_word[OCEN_BIT] ? ST_OC_BURST : ST_CONV;
                    end else begin
                        err_d = 1'b1;
                    end
                end
            end
            ST_OC_BURST: begin
                tmr_d = tmr_q + TMR_ONE;
                if (tmr_q == BURST_END) begin
                    state_d = ST_OC_WAIT; // [R11]
                end
            end
            ST_OC_WAIT: begin
                tmr_d = tmr_q + TMR_ONE;
                if (tmr_q == LEAD_END) begin
                    state_d = ST_CONV; // [R11]
                end
            end
            ST_CONV: begin
                if (adc_done) begin
                    fault_d = fault_d || adc_fault;
                    state_d = custom_q ? ST_FETCH : ST_COMP; // [R4]
                end
            end
            ST_FETCH: begin
                if (fetch_ack) begin
                    state_d = ST_COMP;
                end
            end
            ST_COMP: begin
                if (comp_done) begin
                    result_d = comp_result; // [R7]
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (state_q == ST_COMP && comp_done) begin
            done_d = 1'b1;
        end
        if (start_cmd && !new_ok) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            meas_q <= '0;
            fetch_q <= '0;
            custom_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            fault_q <= 1'b0;
            result_q <= RESULT_RST;
            chan_q <= 5'h00;
        end else if (ce) begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            meas_q <= meas_d;
            fetch_q <= fetch_d;
            custom_q <= custom_d;
            done_q <= done_d;
            err_q <= err_d;
            fault_q <= fault_d;
            result_q <= result_d;
            chan_q <= chan_d;
        end
    end

    assign oc_burst = (state_q == ST_OC_BURST); // [R10] [R11]
    assign adc_req = (state_q == ST_CONV);
    assign cj_req = (state_q == ST_CONV); // [R6]
    assign fetch_req = (state_q == ST_FETCH); // [R4]
    assign comp_req = (state_q == ST_COMP); // [R7]
    assign meas = meas_q;
    assign fetch = fetch_q;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [4:0] a_idx;
    logic [31:0] a_word;
    assign a_idx = meas_q.tc_chan - CH_FIRST;
    assign a_word = cfg_q[a_idx];

    sequence s_burst_end;
        $fell(oc_burst);
    endsequence

    sequence s_conv_start;
        $rose(adc_req) && meas_q.open_circuit_detect_enable;
    endsequence

    a_word_per_chan: assert property ( // [R1]
        adc_req |-> meas_q.tc_chan >= CH_FIRST && meas_q.tc_chan <= CH_LAST
            && meas_q.cj_chan == a_word[CJ_LSB +: 5])
        else $error("channel request does not match its word");
    a_type_field: assert property ( // [R2]
        (adc_req || comp_req) |-> meas_q.tc_type == a_word[TYPE_LSB +: 5])
        else $error("type differs from word bits 31..27");
    a_type_legal: assert property ( // [R3]
        adc_req |-> meas_q.tc_type >= TC_TYPE_FIRST
            && meas_q.tc_type <= TC_TYPE_CUSTOM)
        else $error("conversion with illegal type");
    a_custom_fetch: assert property ( // [R4]
        (adc_req && adc_done && ce) |=>
            (fetch_req == (meas_q.tc_type == TC_TYPE_CUSTOM)))
        else $error("custom fetch step wrong");
    a_cj_together: assert property ( // [R5]
        $rose(adc_req) |-> $rose(cj_req) && meas_q.cj_chan >= CH_FIRST
            && meas_q.cj_chan <= CH_LAST)
        else $error("cold junction not measured with channel");
    a_cj_held: assert property ( // [R6]
        (adc_req && !adc_done) |=> cj_req)
        else $error("cold junction request dropped early");
    a_comp_result: assert property ( // [R7]
        (comp_req && comp_done && ce) |=>
            result_q == $past(comp_result) && done_q && !comp_req)
        else $error("compensated result not captured");
    a_input_mode: assert property ( // [R8]
        adc_req |-> meas_q.differential_select == !a_word[SGL_BIT])
        else $error("input mode differs from bit 21");
    a_neg_input: assert property ( // [R9]
        (adc_req && meas_q.differential_select) |->
            meas_q.neg_chan == meas_q.tc_chan - CH_FIRST)
        else $error("differential return not next lower channel");
    a_open_circuit_current_select: assert property ( // [R10]
        oc_burst |-> a_word[OCEN_BIT] && meas_q.open_circuit_current_select
            == a_word[OCCUR_LSB +: 2])
        else $error("open circuit current mismatch");
    a_oc_burst_len: assert property ( // [R11]
        s_burst_end |-> tmr_q == TMR_W'(BURST_CYC))
        else $error("open circuit burst length wrong");
    a_oc_lead: assert property ( // [R11]
        s_conv_start |-> tmr_q == TMR_W'(LEAD_CYC))
        else $error("conversion not 50 ms after burst start");
    a_custom_field: assert property ( // [R12]
        fetch_req |-> fetch_q.addr == a_word[CADDR_LSB +: 6]
            && fetch_q.len_m1 == a_word[CLEN_LSB +: 6])
        else $error("custom pointer fields wrong");

endmodule // tcc_channel_cfg

// ### tb/tcc_engine_model.sv
module tcc_engine_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic adc_req,
    input wire logic cj_req,
    input wire logic fetch_req,
    input wire logic comp_req,
    input wire logic [3:0] lat,
    input wire logic fault_en,
    input wire logic [31:0] res_val,
    output logic adc_done,
    output logic adc_fault,
    output logic fetch_ack,
    output logic comp_done,
    output logic [31:0] comp_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    logic req;
    logic ack;
    // Conversion only answered when the cold junction is measured too
    assign req = (adc_req && cj_req) || fetch_req || comp_req;
    assign ack = adc_done || fetch_ack || comp_done;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            adc_done <= 1'b0;
            fetch_ack <= 1'b0;
            comp_done <= 1'b0;
        end else begin
            adc_done <= 1'b0;
            fetch_ack <= 1'b0;
            comp_done <= 1'b0;
            if (req && !ack) begin
                if (cnt_q == lat) begin
                    cnt_q <= 4'h0;
                    adc_done <= adc_req && cj_req;
                    fetch_ack <= fetch_req;
                    comp_done <= comp_req;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
    // Outside the answer cycle the lines show the inverse value
    assign adc_fault = adc_done ? fault_en : !fault_en;
    assign comp_result = comp_done ? res_val : ~res_val;
endmodule // tcc_engine_model

// ### tb/thermocouple_channel_config_tb_top.sv
module thermocouple_channel_config_tb_top;
    import tcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BURST = 4;
    localparam int unsigned LEAD = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, comp_result;
    logic oc_burst, adc_req, cj_req, adc_done, adc_fault;
    logic fetch_req, fetch_ack, comp_req, comp_done;
    tcc_meas_s meas;
    tcc_fetch_s fetch, fetch_q;
    logic [3:0] lat = 4'h0;
    logic fault_en = 1'b0;
    logic [31:0] res_val = 32'h0000_0000;
    int n_errors = 0, samples_checked = 0;
    int oc_len = 0, lead = 0, f_cnt = 0;
    logic lead_run = 1'b0, oc_q = 1'b0, ce = 1'b1;

    always #25 aclk = ~aclk;

    tcc_channel_cfg #(.BURST_CYC(BURST), .LEAD_CYC(LEAD)) dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .oc_burst(oc_burst), .adc_req(adc_req),
        .cj_req(cj_req), .meas(meas), .adc_done(adc_done),
        .adc_fault(adc_fault), .fetch_req(fetch_req), .fetch(fetch),
        .fetch_ack(fetch_ack), .comp_req(comp_req),
        .comp_done(comp_done), .comp_result(comp_result));

    tcc_engine_model eng (
        .aclk(aclk), .aresetn(aresetn), .adc_req(adc_req),
        .cj_req(cj_req), .fetch_req(fetch_req), .comp_req(comp_req),
        .lat(lat), .fault_en(fault_en), .res_val(res_val),
        .adc_done(adc_done), .adc_fault(adc_fault),
        .fetch_ack(fetch_ack), .comp_done(comp_done),
        .comp_result(comp_result));

    // Burst length, burst-to-conversion lead and fetches of one run
    always @(posedge aclk) begin
        if (awvalid && awaddr == CTRL_OFF) begin
            oc_len <= 0;
            lead <= 0;
            lead_run <= 1'b0;
            f_cnt <= 0;
        end else begin
            if (oc_burst === 1'b1) oc_len <= oc_len + 1;
            if (oc_burst === 1'b1 && !oc_q) begin
                lead <= 1;
                lead_run <= 1'b1;
            end else if (lead_run && adc_req !== 1'b1) lead <= lead + 1;
            else lead_run <= 1'b0;
            if (fetch_req === 1'b1 && fetch_ack === 1'b1) begin
                f_cnt <= f_cnt + 1;
                fetch_q <= fetch;
            end
        end
        oc_q <= (oc_burst === 1'b1);
    end

    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] exp);
        bit ah, wh, bh;
        logic [1:0] r;
        int n;
        n = 0;
        bh = 0;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
        wstrb <= s; bready <= 1'b1;
        while (!bh && n < 200) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        chk(bh && r === exp, "write response");
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        bit ah, rh;
        int n;
        n = 0;
        rh = 0;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        while (!rh && n < 200) begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!rh) chk(0, "read hang");
    endtask

    // Unused bits 17..12 always written as zero
    function automatic logic [31:0] mk(input logic [4:0] t, c,
        input logic single_ended_select, oc, input logic [1:0] cur, input logic [5:0] ad,
        input logic [5:0] ln);
        return {t, c, single_ended_select, oc, cur, 6'h00, ad, ln};
    endfunction

    task automatic run_meas(input logic [4:0] ch, input logic [31:0] w,
                            input bit bad);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        tcc_meas_s m;
        bit cust;
        m = '{ch, w[31:27], w[26:22], !w[21], w[21] ? 5'h00 : ch - 5'h01,
              w[20], w[19:18]};
        cust = (w[31:27] == TC_TYPE_CUSTOM);
        n = 0;
        axi_wr(CFG_BASE + 12'(4 * (ch - 1)), w, 4'hF, RESP_OKAY);
        axi_wr(CTRL_OFF, 32'h0000_0080 | 32'(ch), 4'h1, RESP_OKAY);
        if (bad) begin
            axi_rd(STAT_OFF, d, r);
            chk(d[STAT_ERR_BIT] === 1'b1 && d[STAT_BUSY_BIT] === 1'b0 &&
                adc_req === 1'b0, "bad word started a run");
        end else begin
            do begin
                @(negedge aclk);
                n++;
            end while (adc_req !== 1'b1 && n < 200);
            chk(meas === m, "measurement fields");
            chk(cj_req === 1'b1, "cold junction not requested");
            do begin
                axi_rd(STAT_OFF, d, r);
                n++;
            end while (d[STAT_BUSY_BIT] !== 1'b0 && n < 400);
            chk(d[STAT_DONE_BIT] === 1'b1 &&
                d[STAT_FAULT_BIT] === fault_en, "status after run");
            axi_rd(RESULT_OFF, d, r);
            chk(d === res_val, "compensated result");
            chk(oc_len == (w[20] ? BURST : 0) &&
                (!w[20] || lead == LEAD), "open circuit timing");
            chk(f_cnt == (cust ? 1 : 0) && (!cust ||
                fetch_q === {w[11:6], w[5:0]}), "custom fetch");
        end
        axi_wr(STAT_OFF, 32'h0000_000E, 4'h1, RESP_OKAY);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(CFG_BASE, d, r);
        chk(d === CFG_RST && r === RESP_OKAY, "config reset value");
        axi_rd(STAT_OFF, d, r);
        chk(d === 32'h0000_0000, "status reset value");
        axi_rd(RESULT_OFF, d, r);
        chk(d === RESULT_RST, "result reset value");
        axi_rd(12'h010, d, r);
        chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
        axi_wr(12'h010, 32'h1234_5678, 4'hF, RESP_SLVERR);
        axi_wr(CFG_LAST, 32'hA5A5_5A5A, 4'hF, RESP_OKAY);
        axi_rd(CFG_LAST, d, r);
        chk(d === 32'hA5A5_5A5A, "last channel word");
        axi_wr(CFG_BASE + 12'h008, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        axi_wr(CFG_BASE + 12'h008, 32'h0000_0000, 4'h1, RESP_OKAY);
        axi_rd(CFG_BASE + 12'h008, d, r);
        chk(d === 32'hFFFF_FF00, "byte strobe merge");
        ce <= 1'b0;
        fork
            axi_wr(CFG_BASE, 32'h0BAD_F00D, 4'hF, RESP_OKAY);
            begin
                repeat (4) @(negedge aclk);
                chk(awready === 1'b0 && bvalid === 1'b0, "bus ran frozen");
                @(posedge aclk);
                ce <= 1'b1;
            end
        join
        axi_rd(CFG_BASE, d, r);
        chk(d === 32'h0BAD_F00D, "write lost over enable low");
        $display("test registers done");
    endtask

    task automatic t_types();
        for (int t = 1; t <= 8; t++) begin
            lat <= 4'(t - 1);
            res_val <= 32'h0001_0000 + 32'(t);
            run_meas(5'h02, mk(5'(t), (t == 8) ? CH_LAST : CH_FIRST,
                     1'b1, 1'b0, 2'h0, 6'h00, 6'h00), 0);
        end
        $display("test rom types done");
    endtask

    task automatic t_oc_custom();
        fault_en <= 1'b1;
        lat <= 4'h5;
        res_val <= 32'hC0DE_0009;
        run_meas(5'h07, mk(TC_TYPE_CUSTOM, CH_LAST, 1'b0, 1'b1, 2'h3,
                 6'h2A, 6'h15), 0);
        fault_en <= 1'b0;
        lat <= 4'h0;
        res_val <= 32'h0000_0BEE;
        run_meas(5'h04, mk(5'h02, 5'h03, 1'b1, 1'b1, 2'h1,
                 6'h00, 6'h00), 0);
        $display("test open circuit and custom done");
    endtask

    task automatic t_invalid();
        logic [4:0] ch [5] = '{5'h05, 5'h05, 5'h05, 5'h05, 5'h01};
        logic [4:0] ty [5] = '{5'h00, 5'h0A, 5'h02, 5'h02, 5'h02};
        logic [4:0] cj [5] = '{5'h01, 5'h01, 5'h00, 5'h15, 5'h03};
        for (int i = 0; i < 5; i++) begin
            run_meas(ch[i], mk(ty[i], cj[i], i != 4, 1'b0, 2'h0,
                     6'h00, 6'h00), 1);
        end
        $display("test invalid words done");
    endtask

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge aclk);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_types();
        t_oc_custom();
        t_invalid();
        results();
    end
endmodule // thermocouple_channel_config_tb_top
